// >>> hdl/scr_lock.sv
// digital lock detect: counts consecutive in-window detector cycles
module scr_lock
  import scr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic pfd_tick_i,
  input wire logic in_window_i,
  input wire logic precision_i,
  input wire logic clear_i,
  output logic lock_o
);

  logic [5:0] run_cnt;
  logic [5:0] target;

  assign target = precision_i ? LOCK_CNT_HI : LOCK_CNT_LO;

  // a single out-of-window cycle restarts the run and drops lock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || clear_i) begin
      run_cnt <= 6'h00;
      lock_o <= 1'b0;
    end else if (pfd_tick_i) begin
      if (!in_window_i) begin
        run_cnt <= 6'h00;
        lock_o <= 1'b0;
      end else if (run_cnt < target) begin
        run_cnt <= 6'(run_cnt + 6'h01);
        lock_o <= (6'(run_cnt + 6'h01) == target);
      end
    end
  end

  a_lock_run_len: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) $rose(lock_o) |-> $past(run_cnt) == 6'(target - 6'h01))
    else $error("lock set before the required run of cycles");

endmodule

// >>> hdl/scr_pkg.sv
// package of constants and types for the synthesizer control register bank
package scr_pkg;

  // ****************************************************
  // latch select codes in the low three bits of a word
  // ****************************************************
  localparam logic [2:0] SEL_FRACTIONAL_NUMERATOR_INT = 3'h0;
  localparam logic [2:0] SEL_FRACTIONAL_NUMERATOR_LOW = 3'h1;
  localparam logic [2:0] SEL_REF_DIV = 3'h2;
  localparam logic [2:0] SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SEL_TEST = 3'h4;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int WORD_W = 32;
  localparam int MUX_HI = 30;
  localparam int MUX_LO = 27;
  localparam int INT_HI = 26;
  localparam int INT_LO = 15;
  localparam int FMSB_HI = 14;
  localparam int FMSB_LO = 3;
  localparam int FLSB_HI = 27;
  localparam int FLSB_LO = 15;
  localparam int FLSB_SHIFT = 13;
  localparam int SLIP_BIT = 28;
  localparam int CPI_HI = 27;
  localparam int CPI_LO = 24;
  localparam int PRESC_BIT = 22;
  localparam int HALVE_BIT = 21;
  localparam int DBL_BIT = 20;
  localparam int RCNT_HI = 19;
  localparam int RCNT_LO = 15;
  localparam int MODRST_BIT = 14;
  localparam int LOCK_PREC_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PD_BIT = 5;
  localparam int HIZ_BIT = 4;
  localparam int HOLD_BIT = 3;
  localparam int BLEED_HI = 24;
  localparam int BLEED_LO = 23;
  localparam int FLMODE_HI = 20;
  localparam int FLMODE_LO = 19;
  localparam int FLTIM_HI = 18;
  localparam int FLTIM_LO = 7;

  localparam logic [1:0] BLEED_ON = 2'h3;
  localparam logic [1:0] FL_SWITCHED_R = 2'h1;

  // ****************************************************
  // reset values and counts
  // ****************************************************
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [5:0] LOCK_CNT_LO = 6'h18;
  localparam logic [5:0] LOCK_CNT_HI = 6'h28;

  typedef struct packed {
    logic [3:0] mux_sel;
    logic [11:0] int_value;
    logic [24:0] fractional_numerator;
    logic [3:0] pump_current_code;
    logic slip_reduction_enable;
    logic prescaler_select;
    logic detector_polarity;
    logic power_down;
    logic pump_high_z;
    logic counter_hold;
    logic bleed_current_enable;
  } scr_ctrl_t;

  typedef enum logic {FL_IDLE, FL_WIDE} scr_fl_state_t;

endpackage

// >>> hdl/scr_shift.sv
// serial input shift register with latch strobe detection
module scr_shift
  import scr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic latch_strobe_i,
  output logic [31:0] word_o,
  output logic word_valid_o
);

  logic [31:0] sreg;
  logic ser_clk_q;
  logic strobe_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ser_clk_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      ser_clk_q <= ser_clk_i;
      strobe_q <= latch_strobe_i;
    end
  end

  // msb first: the first bit ends up in bit 31
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sreg <= WORD_RST;
    end else if (ser_clk_i && !ser_clk_q) begin
      sreg <= {sreg[30:0], ser_data_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      word_o <= WORD_RST;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= latch_strobe_i && !strobe_q;
      if (latch_strobe_i && !strobe_q) begin
        word_o <= sreg;
      end
    end
  end

endmodule

// >>> hdl/scr_top.sv
// synthesizer control register bank: latches, decode and reference path
// Operation
// - codes 000,001,010 load first three latches
// - codes 011,100 load function and test latch
// - fractional_numerator/int bits 30:27 select muxed output
// - twelve-bit integer division value loaded
// - numerator = low field plus high times 2^13
// - slip reduction bit enables cycle slip reduction
// - reference word bits 27:24 set pump current
// - halving bit adds toggle after reference counter
// - doubler bit makes both reference edges active
// - reference counter divides by 1 to 32
// - modulator reset per integer write unless inhibited
// - lock after 24 or 40 in-window cycles
// - function bit 6 sets detector polarity
// - power-down bit; contents kept while down
// - power-down: counters load, pump off, lock cleared
// - function bit 4 puts pump high-z
// - function bit 3 holds counters in reset
// - test bits 24:23 at 11 enable bleed
// - test bits 20:19 at 01 enable fastlock
// - test bits 18:7 set fastlock timer
// - serial data shifted msb first, 32 bits
// - strobe rising edge copies word to latch
// - buffered settings apply on next integer write
module scr_top
  import scr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic latch_strobe_i,
  input wire logic reference_input_i,
  input wire logic phase_in_window_i,
  output scr_ctrl_t ctrl_o,
  output logic pfd_ref_o,
  output logic lock_detect_o,
  output logic modulator_reset_o,
  output logic fastlock_active_o
);

  // ****************************************************
  // serial front end
  // ****************************************************
  logic [31:0] word;
  logic word_valid;

  scr_shift u_shift (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i),
    .latch_strobe_i(latch_strobe_i),
    .word_o(word),
    .word_valid_o(word_valid)
  );

  logic [2:0] register_select;
  logic wr_int;
  logic wr_low;
  logic wr_ref;
  logic wr_fn;
  logic wr_test;

  assign register_select = word[2:0];
  assign wr_int = word_valid && (register_select == SEL_FRACTIONAL_NUMERATOR_INT);
  assign wr_low = word_valid && (register_select == SEL_FRACTIONAL_NUMERATOR_LOW);
  assign wr_ref = word_valid && (register_select == SEL_REF_DIV);
  assign wr_fn = word_valid && (register_select == SEL_FUNCTION);
  assign wr_test = word_valid && (register_select == SEL_TEST);

  // ****************************************************
  // the five latches
  // ****************************************************
  logic [31:0] fractional_numerator_int_word;
  logic [31:0] fractional_numerator_low_word;
  logic [31:0] ref_divider_word;
  logic [31:0] function_word;
  logic [31:0] test_word;

  // codes above 100 match no latch and are dropped
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fractional_numerator_int_word <= WORD_RST;
      fractional_numerator_low_word <= WORD_RST;
      ref_divider_word <= WORD_RST;
      function_word <= WORD_RST;
      test_word <= WORD_RST;
    end else begin
      if (wr_int) fractional_numerator_int_word <= word;
      if (wr_low) fractional_numerator_low_word <= word;
      if (wr_ref) ref_divider_word <= word;
      if (wr_fn) function_word <= word;
      if (wr_test) test_word <= word;
    end
  end

  // ****************************************************
  // double-buffered copies, taken on an integer write
  // ****************************************************
  logic [12:0] flsb_act;
  logic [4:0] rcnt_act;
  logic [3:0] pump_current_code;
  logic dbl_act;
  logic ref_halve_enable;
  logic double_buffered_flag;

  assign double_buffered_flag = wr_int;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      flsb_act <= 13'h0000;
      rcnt_act <= 5'h00;
      pump_current_code <= 4'h0;
      dbl_act <= 1'b0;
      ref_halve_enable <= 1'b0;
    end else if (double_buffered_flag) begin
      // the integer write itself lands in the same cycle, so the
      // buffered values come from the latches written earlier
      flsb_act <= fractional_numerator_low_word[FLSB_HI:FLSB_LO];
      rcnt_act <= ref_divider_word[RCNT_HI:RCNT_LO];
      pump_current_code <= ref_divider_word[CPI_HI:CPI_LO];
      dbl_act <= ref_divider_word[DBL_BIT];
      ref_halve_enable <= ref_divider_word[HALVE_BIT];
    end
  end

  // ****************************************************
  // decoded control outputs
  // ****************************************************
  logic power_down_bit;
  logic counters_stop;
  scr_ctrl_t next_ctrl;

  assign power_down_bit = function_word[PD_BIT];
  assign counters_stop = power_down_bit || function_word[HOLD_BIT];

  always_comb begin
    next_ctrl.mux_sel = fractional_numerator_int_word[MUX_HI:MUX_LO];
    next_ctrl.int_value = fractional_numerator_int_word[INT_HI:INT_LO];
    next_ctrl.fractional_numerator =
      {fractional_numerator_int_word[FMSB_HI:FMSB_LO], flsb_act};
    next_ctrl.pump_current_code = pump_current_code;
    next_ctrl.slip_reduction_enable = ref_divider_word[SLIP_BIT];
    next_ctrl.prescaler_select = ref_divider_word[PRESC_BIT];
    next_ctrl.detector_polarity = function_word[POL_BIT];
    next_ctrl.power_down = power_down_bit;
    next_ctrl.pump_high_z =
      function_word[HIZ_BIT] || power_down_bit;
    next_ctrl.counter_hold = counters_stop;
    next_ctrl.bleed_current_enable =
      (test_word[BLEED_HI:BLEED_LO] == BLEED_ON);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o <= next_ctrl;
    end
  end

  // ****************************************************
  // modulator reset pulse
  // ****************************************************
  logic modulator_reset_inhibit;

  assign modulator_reset_inhibit = function_word[MODRST_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      modulator_reset_o <= 1'b0;
    end else begin
      modulator_reset_o <= wr_int && !modulator_reset_inhibit;
    end
  end

  // ****************************************************
  // reference path: doubler, counter, halving toggle
  // ****************************************************
  logic ref_q;
  logic ref_edge;
  logic [4:0] r_cnt;
  logic r_last;
  logic halve_tog;

  // without the doubler only the falling edge counts
  assign ref_edge = (ref_q && !reference_input_i) ||
                    (dbl_act && !ref_q && reference_input_i);
  // code 0 wraps to 31, giving the ratio of 32
  assign r_last = (r_cnt == 5'(rcnt_act - 5'h01));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= reference_input_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || counters_stop) begin
      r_cnt <= 5'h00;
      halve_tog <= 1'b0;
      pfd_ref_o <= 1'b0;
    end else begin
      pfd_ref_o <= 1'b0;
      if (ref_edge) begin
        if (r_last) begin
          r_cnt <= 5'h00;
          halve_tog <= ref_halve_enable && !halve_tog;
          pfd_ref_o <= !ref_halve_enable || halve_tog;
        end else begin
          r_cnt <= 5'(r_cnt + 5'h01);
        end
      end
    end
  end

  // ****************************************************
  // lock detect
  // ****************************************************
  scr_lock u_lock (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pfd_tick_i(pfd_ref_o),
    .in_window_i(phase_in_window_i),
    .precision_i(function_word[LOCK_PREC_BIT]),
    .clear_i(power_down_bit),
    .lock_o(lock_detect_o)
  );

  // ****************************************************
  // fastlock timer
  // ****************************************************
  scr_fl_state_t fl_state;
  logic [11:0] fastlock_timer_value;
  logic [11:0] fl_cnt;
  logic fl_mode;

  assign fl_mode = (test_word[FLMODE_HI:FLMODE_LO] == FL_SWITCHED_R);
  assign fastlock_timer_value = test_word[FLTIM_HI:FLTIM_LO];

  // the wide-bandwidth window opens on an integer write in fastlock mode with a nonzero timer, unless already open
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || counters_stop) begin
      fl_state <= FL_IDLE;
      fl_cnt <= 12'h000;
    end else begin
      unique case (fl_state)
        FL_IDLE: begin
          if (wr_int && fl_mode && fastlock_timer_value != 12'h000) begin
            fl_state <= FL_WIDE;
            fl_cnt <= fastlock_timer_value;
          end
        end
        FL_WIDE: begin
          if (!fl_mode) begin
            fl_state <= FL_IDLE;
          end else if (pfd_ref_o) begin
            fl_cnt <= 12'(fl_cnt - 12'h001);
            if (fl_cnt == 12'h001) fl_state <= FL_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fastlock_active_o <= 1'b0;
    end else begin
      fastlock_active_o <= (fl_state == FL_WIDE) && !counters_stop;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  // integer write, then the cycle in which the buffered copies settle
  sequence s_int_written;
    wr_int ##1 !wr_int;
  endsequence

  sequence s_pd_held;
    power_down_bit [*3];
  endsequence

  a_int_latch_load: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) wr_int |=> fractional_numerator_int_word == $past(word))
    else $error("integer word not loaded");

  a_test_latch_load: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    wr_test |=> (test_word == $past(word)) ##1 (ctrl_o.bleed_current_enable
      == (test_word[BLEED_HI:BLEED_LO] == BLEED_ON)))
    else $error("test word not loaded or decoded");

  a_mux_sel_field: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    wr_int |-> ##2 ctrl_o.mux_sel == $past(word[MUX_HI:MUX_LO], 2))
    else $error("mux select not taken from bits 30:27");

  a_fractional_numerator_assemble: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    s_int_written |-> ##1 ctrl_o.fractional_numerator[12:0]
      == $past(fractional_numerator_low_word[FLSB_HI:FLSB_LO], 2))
    else $error("fractional low field not applied after integer write");

  a_low_buffered: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    wr_low && !wr_int ##1 !wr_int |=> ctrl_o.fractional_numerator[12:0]
      == $past(ctrl_o.fractional_numerator[12:0]))
    else $error("low fraction applied without integer write");

  a_mod_reset_pulse: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    modulator_reset_o |-> $past(wr_int) && !$past(modulator_reset_inhibit))
    else $error("modulator reset without enabled integer write");

  a_pd_lock_clear: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    s_pd_held |-> !lock_detect_o && !pfd_ref_o && ctrl_o.pump_high_z)
    else $error("power-down left lock, counters or pump active");

  a_hold_no_ref: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    $past(counters_stop) |-> !pfd_ref_o && r_cnt == 5'h00)
    else $error("reference counter ran while held");

  a_fastlock_load: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i || counters_stop)
    fl_state == FL_IDLE && wr_int && fl_mode &&
      fastlock_timer_value != 12'h000
      |=> fl_cnt == $past(fastlock_timer_value) ##1 fastlock_active_o)
    else $error("fastlock timer not started");

endmodule

// >>> verification/scr_host_model.sv
// host model that programs the register bank over the three-wire link
module scr_host_model (
  input wire logic sys_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic latch_strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // link clock stands still low between frames
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    latch_strobe_o = 1'b0;
  end

  // s sets how many system cycles each link level lasts
  task automatic send_word(input logic [31:0] w, input int s);
    for (int i = 31; i >= 0; i--) begin
      ser_data_o <= w[i];
      repeat (s) @(posedge sys_clk_i);
      ser_clk_o <= 1'b1;
      repeat (s) @(posedge sys_clk_i);
      ser_clk_o <= 1'b0;
    end
    repeat (s) @(posedge sys_clk_i);
    latch_strobe_o <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    latch_strobe_o <= 1'b0;
    // line is no longer meaningful: show the inverse rather than a hold
    ser_data_o <= ~w[0];
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// >>> verification/tb_scr_top.sv
// self-checking bench for the synthesizer control register bank
module tb_scr_top
  import scr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ref_in = 1'b0;
  logic in_win = 1'b0;
  logic ser_clk;
  logic ser_data;
  logic strobe;
  scr_ctrl_t ctrl;
  logic pfd_ref;
  logic lock;
  logic mod_rst;
  logic fl_act;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int pfd_cnt = 0;
  int mod_cnt = 0;
  int p0;
  logic [31:0] r0w;

  scr_host_model scr_host_model_i (.sys_clk_i(sys_clk),
    .ser_clk_o(ser_clk), .ser_data_o(ser_data), .latch_strobe_o(strobe));

  scr_top scr_top_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .ser_clk_i(ser_clk), .ser_data_i(ser_data), .latch_strobe_i(strobe),
    .reference_input_i(ref_in), .phase_in_window_i(in_win),
    .ctrl_o(ctrl), .pfd_ref_o(pfd_ref), .lock_detect_o(lock),
    .modulator_reset_o(mod_rst), .fastlock_active_o(fl_act));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ceiling is several times the expected run of about 3000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (pfd_ref === 1'b1) pfd_cnt++;
    if (mod_rst === 1'b1) mod_cnt++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic send(input logic [31:0] w, input int s = 1);
    scr_host_model_i.send_word(w, s);
  endtask

  function automatic logic [31:0] fw(input logic mr, prec, pol, pd, hiz,
                                     hold);
    return {17'h0, mr, 6'h0, prec, pol, pd, hiz, hold, SEL_FUNCTION};
  endfunction

  function automatic logic [31:0] rw(input logic halve, dbl);
    return {3'h0, 1'b1, 4'h5, 1'b0, 1'b1, halve, dbl, 5'h03, 12'h0,
            SEL_REF_DIV};
  endfunction

  // falling edges of the reference, two system cycles per level
  task automatic run_ref(input int falls);
    for (int i = 0; i < falls; i++) begin
      repeat (2) @(posedge sys_clk);
      ref_in <= 1'b1;
      repeat (2) @(posedge sys_clk);
      ref_in <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // ratio 3: one detector tick per three falls
  task automatic lock_run(input logic prec, input int n);
    send(fw(1'b1, prec, 1'b1, 1'b0, 1'b0, 1'b0));
    in_win <= 1'b0;
    run_ref(3);
    in_win <= 1'b1;
    run_ref(3 * (n - 1));
    chk("lock_early", 0, lock);
    run_ref(3);
    chk("lock_set", 1, lock);
  endtask

  task automatic ref_case(input logic [31:0] div_word, input int falls,
                          input int exp);
    send(div_word);
    send(fw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
    chk("counter_hold", 1, ctrl.counter_hold);
    send(fw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    send(r0w);
    p0 = pfd_cnt;
    run_ref(falls);
    chk("pfd_pulses", exp, pfd_cnt - p0);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    r0w = {1'b0, 4'hC, 12'h244, 12'h051, SEL_FRACTIONAL_NUMERATOR_INT};
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("ctrl_reset", 0, ctrl);
    send(32'h0188_0184, 3);
    chk("bleed", 1, ctrl.bleed_current_enable);
    send(fw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0), 3);
    chk("polarity", 1, ctrl.detector_polarity);
    send(rw(1'b0, 1'b0));
    chk("slip", 1, ctrl.slip_reduction_enable);
    chk("presc", 1, ctrl.prescaler_select);
    chk("cpi_buffered", 0, ctrl.pump_current_code);
    send({4'h0, 13'h1D71, 12'h0, SEL_FRACTIONAL_NUMERATOR_LOW});
    chk("fractional_numerator_buffered", 0, ctrl.fractional_numerator);
    p0 = mod_cnt;
    send(r0w);
    chk("mux_sel", 4'hC, ctrl.mux_sel);
    chk("int_value", 12'h244, ctrl.int_value);
    chk("fractional_numerator", (64'h51 << 13) + 64'h1D71, ctrl.fractional_numerator);
    chk("cpi", 4'h5, ctrl.pump_current_code);
    chk("mod_reset", 1, mod_cnt - p0);
    chk("fastlock_on", 1, fl_act);
    p0 = pfd_cnt;
    run_ref(8);
    chk("fastlock_mid", 1, fl_act);
    run_ref(16);
    chk("fastlock_off", 0, fl_act);
    chk("pfd_div3", 8, pfd_cnt - p0);
    send(32'hFFFF_FFFD);
    chk("bad_select", 12'h244, ctrl.int_value);
    send(fw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    p0 = mod_cnt;
    send(r0w);
    chk("mod_inhibit", 0, mod_cnt - p0);
    lock_run(1'b0, 24);
    lock_run(1'b1, 40);
    send(fw(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0), 3);
    chk("power_down", 1, ctrl.power_down);
    chk("pd_lock", 0, lock);
    chk("pd_high_z", 1, ctrl.pump_high_z);
    chk("pd_hold", 1, ctrl.counter_hold);
    chk("pd_kept", 12'h244, ctrl.int_value);
    send(fw(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
    chk("wake", 0, ctrl.power_down);
    chk("high_z", 1, ctrl.pump_high_z);
    send(fw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    chk("high_z_off", 0, ctrl.pump_high_z);
    in_win <= 1'b0;
    ref_case(rw(1'b0, 1'b1), 12, 8);
    ref_case(rw(1'b1, 1'b0), 24, 4);
    wrap_up();
  end
endmodule
